// *** core/isrc_top.sv ***
`timescale 1ns/1ps
// What this block does
// - idle bus plus start request starts, waits
// - released bus starts, busy bus reserves
// - after stop, shift write starts master transfer
// - shift writes before stop while reserved dropped
// - reservation accepted between start and stop
// - reservation disabled, busy bus rejects start
// - start fail flag settles within five clocks
// - exit or disable means bus unused
// - enable forces busy when start-without-stop off
// - enable clears busy when start-without-stop on
// - enable during low data detects a start
module isrc_top
  import isrc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_n,
  output logic bus_interrupt
);

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == OFF_CTRL) || (a == OFF_CFG) || (a == OFF_STAT) ||
      (a == OFF_SHIFT) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction : known_addr

  isrc_state_t state;
  isrc_state_t next_state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic enable;
  logic enable_d;
  logic stop_irq_enable;
  logic reservation_disable;
  logic start_without_stop_enable;
  logic [7:0] low_width_setting;
  logic [7:0] high_width_setting;
  logic [7:0] shift_register;
  logic bus_busy_flag;
  logic start_detected;
  logic stop_detected;
  logic master_status;
  logic start_fail_flag;
  logic reserved;
  logic res_ready;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;

  // pin sampling and condition detection
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  wire en_rise = enable & ~enable_d;
  wire start_seen = enable & (start_ev | (en_rise & scl_s & ~sda_s));

  // bus slave decode
  wire wr_go = awvalid & wvalid & ~awready & ~bvalid;
  wire rd_go = arvalid & ~arready & ~rvalid;
  wire wr_lo = wr_go & wstrb[0];
  wire wr_ctrl = wr_lo & (awaddr == OFF_CTRL);
  wire wr_cfg = wr_go & (awaddr == OFF_CFG);
  wire wr_shift = wr_lo & (awaddr == OFF_SHIFT);
  wire wr_iclr = wr_lo & (awaddr == OFF_IRQ_STAT);
  wire wr_imask = wr_lo & (awaddr == OFF_IRQ_MASK);

  // request decode
  wire start_pend = reserved | (state == ST_START_HOLD);
  wire stop_pend = (state == ST_STOP_LOW) | (state == ST_STOP_HOLD);
  wire req_start = wr_ctrl & wdata[CTRL_START_REQ] & enable &
    (state == ST_IDLE) & ~start_pend;
  wire req_stop = wr_ctrl & wdata[CTRL_STOP_REQ] & enable & ~stop_pend &
    ((state == ST_IDLE) | (state == ST_WAIT));
  wire req_exit = wr_ctrl & wdata[CTRL_EXIT];
  wire go_now = req_start & ~bus_busy_flag;
  wire go_rsv = req_start & bus_busy_flag & ~reservation_disable;
  wire go_fail = req_start & bus_busy_flag & reservation_disable;
  wire go_auto = wr_shift & reserved & res_ready & ~bus_busy_flag;
  wire hold_done = (cnt <= 8'h01);
  wire [7:0] high_load = (high_width_setting == 8'h00) ? 8'h01 :
    high_width_setting;
  wire [7:0] low_load = (low_width_setting == 8'h00) ? 8'h01 :
    low_width_setting;
  wire drive_sda = (next_state == ST_START_HOLD) |
    (next_state == ST_STOP_LOW) | (next_state == ST_STOP_HOLD);
  wire drive_scl = (next_state == ST_WAIT) | (next_state == ST_STOP_LOW);
  wire [IRQ_W-1:0] irq_ev = {go_now | go_auto, go_fail, start_seen,
    stop_ev & enable & stop_irq_enable};
  wire [31:0] stat_word = {24'h0000_00, master_status, 2'h0, start_fail_flag,
    reserved, bus_busy_flag, start_detected, stop_detected};
  wire [31:0] ctrl_word = {24'h0000_00, enable, 1'b0, 1'b0, stop_irq_enable,
    2'h0, start_pend, stop_pend};
  wire [31:0] cfg_word = {8'h00, high_width_setting, low_width_setting,
    6'h00, start_without_stop_enable, reservation_disable};
  wire [31:0] rd_word =
    (araddr == OFF_CTRL) ? ctrl_word :
    (araddr == OFF_CFG) ? cfg_word :
    (araddr == OFF_STAT) ? stat_word :
    (araddr == OFF_SHIFT) ? {24'h0000_00, shift_register} :
    (araddr == OFF_IRQ_STAT) ? {28'h0000_000, irq_stat} :
    (araddr == OFF_IRQ_MASK) ? {28'h0000_000, irq_mask} : 32'h0000_0000;

  // start and stop sequencer
  always_comb begin
    next_state = state;
    next_cnt = hold_done ? cnt : cnt - 8'h01;
    unique case (state)
      ST_IDLE: if (go_now | go_auto) begin
        next_state = ST_START_HOLD;
        next_cnt = high_load;
      end else if (req_stop) begin
        next_state = ST_STOP_LOW;
        next_cnt = low_load;
      end
      ST_START_HOLD: if (hold_done) next_state = ST_WAIT;
      ST_WAIT: if (req_stop) begin
        next_state = ST_STOP_LOW;
        next_cnt = low_load;
      end
      ST_STOP_LOW: if (hold_done) begin
        next_state = ST_STOP_HOLD;
        next_cnt = high_load;
      end
      ST_STOP_HOLD: if (hold_done) next_state = ST_IDLE;
    endcase
    if (req_exit | ~enable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      enable_d <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], serial_clock_pin_in};
      sda_sync <= {sda_sync[0], serial_data_pin_in};
      scl_d <= scl_s;
      sda_d <= sda_s;
      enable_d <= enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      serial_clock_pin_oe_n <= 1'b1;
      serial_data_pin_oe_n <= 1'b1;
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      serial_clock_pin_oe_n <= ~drive_scl;
      serial_data_pin_oe_n <= ~drive_sda;
    end
  end

  // software controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= 1'b0;
      stop_irq_enable <= 1'b0;
      reservation_disable <= 1'b0;
      start_without_stop_enable <= 1'b0;
      low_width_setting <= RST_WIDTH;
      high_width_setting <= RST_WIDTH;
      irq_mask <= '0;
    end else begin
      if (wr_ctrl) begin
        enable <= wdata[CTRL_ENABLE];
        stop_irq_enable <= wdata[CTRL_STOP_IRQ_EN];
      end
      if (wr_cfg && wstrb[0]) begin
        reservation_disable <= wdata[CFG_RSV_DIS];
        start_without_stop_enable <= wdata[CFG_START_NO_STOP];
      end
      if (wr_cfg && wstrb[1]) begin
        low_width_setting <= wdata[CFG_LOW_LSB +: 8];
      end
      if (wr_cfg && wstrb[2]) begin
        high_width_setting <= wdata[CFG_HIGH_LSB +: 8];
      end
      if (wr_imask) begin
        irq_mask <= wdata[IRQ_W-1:0];
      end
    end
  end

  // bus state, reservation and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_busy_flag <= 1'b0;
      start_detected <= 1'b0;
      stop_detected <= 1'b0;
      master_status <= 1'b0;
      start_fail_flag <= 1'b0;
      reserved <= 1'b0;
      res_ready <= 1'b0;
      shift_register <= 8'h00;
    end else begin
      if (!enable) begin
        bus_busy_flag <= 1'b0;
      end else if (en_rise) begin
        bus_busy_flag <= ~start_without_stop_enable;
      end else if (start_seen) begin
        bus_busy_flag <= 1'b1;
      end else if (stop_ev) begin
        bus_busy_flag <= 1'b0;
      end
      if (start_seen) begin
        start_detected <= 1'b1;
        stop_detected <= 1'b0;
      end else if (stop_ev & enable) begin
        start_detected <= 1'b0;
        stop_detected <= 1'b1;
      end
      if (go_fail) begin
        start_fail_flag <= 1'b1;
      end else if (req_start) begin
        start_fail_flag <= 1'b0;
      end
      if (req_exit | ~enable) begin
        master_status <= 1'b0;
        reserved <= 1'b0;
        res_ready <= 1'b0;
      end else if (go_now | go_auto) begin
        master_status <= 1'b1;
        reserved <= 1'b0;
        res_ready <= 1'b0;
      end else begin
        if (next_state == ST_IDLE && stop_pend) begin
          master_status <= 1'b0;
        end
        if (go_rsv) begin
          reserved <= 1'b1;
        end
        if (reserved && stop_ev) begin
          res_ready <= 1'b1;
        end else if (start_seen) begin
          res_ready <= 1'b0;
        end
      end
      if (wr_shift && (!reserved || go_auto)) begin
        shift_register <= wdata[7:0];
      end
    end
  end

  // interrupt status, write one to clear, event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      bus_interrupt <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_iclr ? wdata[IRQ_W-1:0] : '0)) | irq_ev;
      bus_interrupt <= |(irq_stat & irq_mask);
    end
  end

  // axi4-lite slave handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      awready <= wr_go;
      wready <= wr_go;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= known_addr(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= rd_go;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= known_addr(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reserve_then_stop;
    go_rsv ##[1:1000] (reserved & res_ready);
  endsequence

  AST_IDLE_START: assert property (go_now |=> state == ST_START_HOLD
    ##[1:256] (state == ST_WAIT || !enable || req_exit))
    else $error("start on idle bus did not reach wait");
  AST_BUSY_RESERVES: assert property (go_rsv |=> reserved &&
    state == ST_IDLE && !master_status)
    else $error("busy bus start was not reserved");
  AST_AUTO_START: assert property (s_reserve_then_stop ##1 go_auto
    |=> master_status && state == ST_START_HOLD)
    else $error("reserved start did not begin after stop");
  AST_DROP_EARLY: assert property (wr_shift && reserved && !res_ready
    |=> $stable(shift_register))
    else $error("shift write before stop was kept");
  AST_ACCEPT_WINDOW: assert property (start_detected && req_start &&
    !reservation_disable && !stop_ev |=> reserved || master_status)
    else $error("reservation refused after start detected");
  AST_REJECT: assert property (go_fail |=> !master_status &&
    state == ST_IDLE [*2])
    else $error("rejected start still generated");
  AST_FAIL_TIME: assert property (go_fail |-> ##[1:5] start_fail_flag)
    else $error("start fail flag late");
  AST_EXIT_RELEASE: assert property (req_exit |=> state == ST_IDLE &&
    !master_status ##1 serial_data_pin_oe_n && serial_clock_pin_oe_n)
    else $error("exit did not release the bus");
  AST_EN_BUSY: assert property (en_rise && !start_without_stop_enable
    |=> bus_busy_flag)
    else $error("enable did not force busy");
  AST_EN_FREE: assert property (en_rise && start_without_stop_enable
    |=> !bus_busy_flag)
    else $error("enable did not force free");
  AST_EN_START: assert property (en_rise && scl_s && !sda_s
    |=> start_detected && irq_stat[IRQ_START])
    else $error("low data at enable not seen as start");

endmodule : isrc_top

// *** core/isrc_pkg.sv ***
package isrc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_SHIFT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // control_register_0 fields
  localparam int CTRL_STOP_REQ = 0;
  localparam int CTRL_START_REQ = 1;
  localparam int CTRL_STOP_IRQ_EN = 4;
  localparam int CTRL_EXIT = 6;
  localparam int CTRL_ENABLE = 7;
  // flag / width configuration fields
  localparam int CFG_RSV_DIS = 0;
  localparam int CFG_START_NO_STOP = 1;
  localparam int CFG_LOW_LSB = 8;
  localparam int CFG_HIGH_LSB = 16;
  // status fields
  localparam int STAT_STOP_DET = 0;
  localparam int STAT_START_DET = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_RESERVED = 3;
  localparam int STAT_START_FAIL = 4;
  localparam int STAT_MASTER = 7;
  // interrupt status / mask fields
  localparam int IRQ_STOP = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_FAIL = 2;
  localparam int IRQ_MASTER = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [7:0] RST_WIDTH = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // start_fail_flag must settle within this many clocks
  localparam int START_FAIL_MAX_CLK = 5;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_HOLD,
    ST_WAIT,
    ST_STOP_LOW,
    ST_STOP_HOLD
  } isrc_state_t;
endpackage : isrc_pkg

// *** test/isrc_bus_peer.sv ***
`timescale 1ns/1ps
module isrc_bus_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  localparam int HALF = 200;
  initial begin
    scl_oe_n = 1'h1;
    sda_oe_n = 1'h1;
  end
  // start condition, then some clocked bits
  task automatic frame_begin(input int bits);
    int n;
    #7;
    for (n = 0; n < 64 && !(scl && sda); n++) #(2 * HALF);
    #(18 * HALF);
    sda_oe_n = 1'h0;
    #HALF;
    for (n = 0; n < bits; n++) begin
      scl_oe_n = 1'h0;
      sda_oe_n = n[0];
      #HALF;
      scl_oe_n = 1'h1;
      #HALF;
    end
  endtask : frame_begin
  // stop condition, then lines released
  task automatic frame_end();
    scl_oe_n = 1'h0;
    sda_oe_n = 1'h0;
    #HALF;
    scl_oe_n = 1'h1;
    #HALF;
    sda_oe_n = 1'h1;
    #HALF;
  endtask : frame_end
endmodule : isrc_bus_peer

// *** test/tb_i2c_start_reservation_control.sv ***
`timescale 1ns/1ps
module tb_i2c_start_reservation_control;
  import isrc_pkg::*;
  localparam int TF_CLK = 1;
  logic aclk = 1'h0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, bus_interrupt;
  logic scl_oe_n, sda_oe_n, p_scl_oe_n, p_sda_oe_n;
  wire scl_w = scl_oe_n & p_scl_oe_n;
  wire sda_w = sda_oe_n & p_sda_oe_n;
  int failures = 0;
  int total_checks = 0;
  always #25 aclk = ~aclk;
  isrc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .serial_clock_pin_in(scl_w),
    .serial_clock_pin_out(), .serial_clock_pin_oe_n(scl_oe_n),
    .serial_data_pin_in(sda_w), .serial_data_pin_out(),
    .serial_data_pin_oe_n(sda_oe_n), .bus_interrupt(bus_interrupt));
  isrc_bus_peer peer (.scl(scl_w), .sda(sda_w), .scl_oe_n(p_scl_oe_n),
    .sda_oe_n(p_sda_oe_n));
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic hang();
    failures++;
    $display("FAIL wait expected done seen timeout");
    print_verdict();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : chkb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    resp = bresp;
    if (n == 64) hang();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    rd_val = rdata;
    resp = rresp;
    if (n == 64) hang();
  endtask : rd
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : wait_cyc
  task automatic wait_bit(input int b, input logic v);
    int n;
    for (n = 0; n < 40; n++) begin
      rd(OFF_STAT);
      if (rd_val[b] === v) break;
    end
    if (n == 40) hang();
  endtask : wait_bit
  task automatic t_reset();
    rd(OFF_CFG);
    chk("cfg", {8'h00, RST_WIDTH, RST_WIDTH, 8'h00}, rd_val);
    rd(OFF_IRQ_MASK);
    chk("mask", 32'h0000_0000, rd_val);
    rd(8'h20);
    chk("resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(8'h20, 32'h0000_0000);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    $display("test reset done");
  endtask : t_reset
  task automatic t_busy_off();
    wr(OFF_CFG, {8'h00, RST_WIDTH, RST_WIDTH, 8'h00});
    wr(OFF_CTRL, 32'h0000_0090);
    rd(OFF_STAT);
    chkb("busy", 1'h1, rd_val[STAT_BUSY]);
    wr(OFF_CTRL, 32'h0000_0091);
    wait_bit(STAT_BUSY, 1'h0);
    chkb("stop_det", 1'h1, rd_val[STAT_STOP_DET]);
    $display("test busy_off done");
  endtask : t_busy_off
  task automatic t_start();
    wr(OFF_CTRL, 32'h0000_0092);
    wait_cyc(2 * RST_WIDTH + 4 + 2 * TF_CLK);
    rd(OFF_STAT);
    chkb("master", 1'h1, rd_val[STAT_MASTER]);
    chkb("reserved", 1'h0, rd_val[STAT_RESERVED]);
    chkb("start_det", 1'h1, rd_val[STAT_START_DET]);
    chkb("sda_oe_n", 1'h1, sda_oe_n);
    chkb("scl_oe_n", 1'h0, scl_oe_n);
    wr(OFF_CTRL, 32'h0000_00d0);
    wait_cyc(4);
    chkb("scl_oe_n", 1'h1, scl_oe_n);
    rd(OFF_STAT);
    chkb("master", 1'h0, rd_val[STAT_MASTER]);
    $display("test start done");
  endtask : t_start
  task automatic t_reserve();
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    peer.frame_begin(4);
    rd(OFF_STAT);
    chkb("start_det", 1'h1, rd_val[STAT_START_DET]);
    wr(OFF_CTRL, 32'h0000_0092);
    wait_cyc(2 * RST_WIDTH + 4 + 2 * TF_CLK);
    rd(OFF_STAT);
    chkb("reserved", 1'h1, rd_val[STAT_RESERVED]);
    chkb("master", 1'h0, rd_val[STAT_MASTER]);
    rd(OFF_CTRL);
    chk("ctrl", 32'h0000_0092, rd_val);
    wr(OFF_SHIFT, 32'h0000_00a5);
    wait_cyc(4);
    chkb("sda_oe_n", 1'h1, sda_oe_n);
    rd(OFF_SHIFT);
    chk("shift", 32'h0000_0000, rd_val);
    peer.frame_end();
    wait_bit(STAT_BUSY, 1'h0);
    wait_cyc(3);
    chkb("irq", 1'h1, bus_interrupt);
    wr(OFF_IRQ_MASK, 32'h0000_0000);
    wait_cyc(3);
    chkb("irq", 1'h0, bus_interrupt);
    rd(OFF_IRQ_STAT);
    chk("irq_stat", 32'h0000_000b, rd_val);
    wr(OFF_IRQ_STAT, 32'h0000_000f);
    rd(OFF_IRQ_STAT);
    chk("irq_stat", 32'h0000_0000, rd_val);
    wr(OFF_SHIFT, 32'h0000_00a0);
    wait_cyc(2 * RST_WIDTH + 4 + 2 * TF_CLK);
    rd(OFF_STAT);
    chkb("master", 1'h1, rd_val[STAT_MASTER]);
    chkb("start_det", 1'h1, rd_val[STAT_START_DET]);
    chkb("scl_oe_n", 1'h0, scl_oe_n);
    rd(OFF_SHIFT);
    chk("shift", 32'h0000_00a0, rd_val);
    wr(OFF_CTRL, 32'h0000_00d0);
    $display("test reserve done");
  endtask : t_reserve
  task automatic t_reject();
    wr(OFF_CFG, {8'h00, RST_WIDTH, RST_WIDTH, 8'h01});
    peer.frame_begin(4);
    wr(OFF_CTRL, 32'h0000_0092);
    wait_cyc(START_FAIL_MAX_CLK);
    rd(OFF_STAT);
    chkb("fail", 1'h1, rd_val[STAT_START_FAIL]);
    chkb("reserved", 1'h0, rd_val[STAT_RESERVED]);
    chkb("sda_oe_n", 1'h1, sda_oe_n);
    peer.frame_end();
    wait_bit(STAT_BUSY, 1'h0);
    wr(OFF_CTRL, 32'h0000_0092);
    wait_cyc(START_FAIL_MAX_CLK);
    rd(OFF_STAT);
    chkb("fail", 1'h0, rd_val[STAT_START_FAIL]);
    wr(OFF_CTRL, 32'h0000_00d0);
    $display("test reject done");
  endtask : t_reject
  task automatic t_join();
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CFG, {8'h00, RST_WIDTH, RST_WIDTH, 8'h02});
    wr(OFF_CTRL, 32'h0000_0090);
    rd(OFF_STAT);
    chkb("busy", 1'h0, rd_val[STAT_BUSY]);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_IRQ_STAT, 32'h0000_000f);
    peer.frame_begin(0);
    wr(OFF_CTRL, 32'h0000_0080);
    wait_bit(STAT_START_DET, 1'h1);
    rd(OFF_IRQ_STAT);
    chkb("start_irq", 1'h1, rd_val[IRQ_START]);
    wr(OFF_CTRL, 32'h0000_00c0);
    chkb("sda_oe_n", 1'h1, sda_oe_n);
    peer.frame_end();
    $display("test join done");
  endtask : t_join
  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_busy_off();
    t_start();
    t_reserve();
    t_reject();
    t_join();
    print_verdict();
  end
endmodule : tb_i2c_start_reservation_control
